// ===== verilog/ardr_consts.svh
`ifndef ARDR_CONSTS_SVH
`define ARDR_CONSTS_SVH
// Register byte offsets
`define ARDR_OFF_CTRL   8'h00
`define ARDR_OFF_STATUS 8'h04
`define ARDR_OFF_DATA   8'h08
`define ARDR_OFF_BAUD   8'h0C
// Control field positions
`define ARDR_C_EN       0
`define ARDR_C_CHAR9    1
`define ARDR_C_WAKE     2
`define ARDR_C_ORIGIN   3
`define ARDR_C_STANDBY  4
// Status field positions
`define ARDR_S_FULL     0
`define ARDR_S_NOISE    1
`define ARDR_S_FRAME    2
`define ARDR_S_IDLE     3
// Reset values
`define ARDR_CTRL_RST   5'h00
`define ARDR_BAUD_RST   16'h0041
// Oversample tick positions inside one bit
`define ARDR_RT1        5'h01
`define ARDR_RT3        5'h03
`define ARDR_RT5        5'h05
`define ARDR_RT7        5'h07
`define ARDR_RT8        5'h08
`define ARDR_RT9        5'h09
`define ARDR_RT10       5'h0A
`define ARDR_RT16       5'h10
// Resync window: edge early in a bit or late in the previous one
`define ARDR_SYNC_LATE  5'h04
`define ARDR_SYNC_EARLY 5'h0D
// Idle detection: ticks per bit (last index) and bit thresholds
`define ARDR_TICK_LAST  4'hF
`define ARDR_IDLE_8     4'hA
`define ARDR_IDLE_9     4'hB
// Data bit counts (last index)
`define ARDR_LAST_8     4'h7
`define ARDR_LAST_9     4'h8
`endif

// ===== verilog/ardr_pkg.sv
package ardr_pkg;
  // Receiver sequence, Gray coded along hunt, start, data, stop
  typedef enum logic [1:0] {
    ARDR_HUNT  = 2'h0,
    ARDR_START = 2'h1,
    ARDR_DATA  = 2'h3,
    ARDR_STOP  = 2'h2
  } ardr_state_t;
endpackage

// ===== verilog/ardr_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
// Divisor and enable out to the tick divider, tick back
interface ardr_tick_if #(parameter int DIV_W = 16);
  logic [DIV_W-1:0] divisor; // Clocks per oversample tick
  logic             enable;  // Divider runs while high
  logic             tick;    // One-cycle oversample pulse
  modport gen (input divisor, input enable, output tick);
  modport user (output divisor, output enable, input tick);
endinterface
`default_nettype wire

// ===== verilog/ardr_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "ardr_consts.svh"
// Divides the clock down to the sixteen-times-baud tick
module ardr_tick_gen import ardr_pkg::*; #(
  parameter int DIV_W = 16
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  ardr_tick_if.gen  tk
);
  logic [DIV_W-1:0] cnt_reg; // Clocks since last tick
  logic             last;    // Final clock of a tick period

  // Divisor of zero or one gives a tick every clock
  assign last = (tk.divisor <= DIV_W'(1)) ||
                (cnt_reg == tk.divisor - DIV_W'(1));

  // Counter and tick pulse; held quiet while disabled
  always_ff @(posedge clk_i) begin
    if (rst_i || !tk.enable) begin
      cnt_reg <= '0;
      tk.tick <= 1'b0;
    end else if (last) begin
      cnt_reg <= '0;
      tk.tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + DIV_W'(1);
      tk.tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/ardr_receiver.sv
// What this block does
// - Sample input each tick at sixteen times baud
// - Realign ticks after start and high-to-low bits
// - Hunt low after three highs, start count
// - Check ticks three, five, seven; flag noise
// - Two or more highs reject, resume hunting
// - Data bit is majority of ticks 8-10
// - High start samples 8-10 only flag noise
// - Stop bit majority vote; low gives framing
// - Framing error raised with receive-full flag
// - Realign on valid falling edges inside character
// - Standby suppresses receiver requests
// - Address mark wake clears standby, sets full
// - Waking idle sets neither idle nor full
// - Idle count origin picks start or stop
// - Standby on idle line may wake at once
// - Origin one counts after stop; reset zero
// - Wake one is address mark; reset zero
// - Character length one selects nine data bits
// - Idle flag after ten or eleven highs
//
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ardr_consts.svh"
module ardr_receiver import ardr_pkg::*; #(
  parameter int DIV_W = 16
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rx_i,
  output logic             rx_request_o
);
  // Tick divider link
  ardr_tick_if #(.DIV_W(DIV_W)) tk ();

  // Input synchroniser
  logic             rx_meta_reg;   // First stage, read only by second
  logic             rx_sync_reg;   // Safe copy of the pin
  // Control register fields
  logic             en_reg;        // Receiver enabled
  logic             char9_reg;     // Nine data bits
  logic             wake_reg;      // Address mark wake when high
  logic             origin_reg;    // Idle count after stop bit
  logic             standby_reg;   // Receiver standby bit
  logic [DIV_W-1:0] baud_reg;      // Clocks per oversample tick
  // Status flags
  logic             full_reg;      // Receive-full flag
  logic             noise_reg;     // Noise flag
  logic             frame_reg;     // Framing error flag
  logic             idle_reg;      // Idle-line flag
  logic [8:0]       data_reg;      // Last delivered character
  // Recovery state
  ardr_state_t      state_reg;     // Sequence position
  logic [4:0]       rt_reg;        // Position of previous sample
  logic [2:0]       hist_reg;      // Last three samples
  logic [1:0]       ones_reg;      // Highs among start checks
  logic             s8_reg;        // Sample at tick eight
  logic             s9_reg;        // Sample at tick nine
  logic             prev_bit_reg;  // Last voted bit was high
  logic [3:0]       bit_idx_reg;   // Data bit being received
  logic [8:0]       shift_reg;     // Assembled data bits
  logic             cnoise_reg;    // Noise seen in this character
  logic             done_reg;      // Character complete pulse
  logic             stop_ok_reg;   // Stop bit voted high
  // Idle detection
  logic [3:0]       idle_tk_reg;   // High ticks within a bit
  logic [3:0]       idle_bits_reg; // Consecutive high bits
  logic             idle_seen_reg; // Threshold already reported
  // Bus slave
  logic             ack_reg;       // Answer pending

  // Combinational helpers
  logic       samp;      // Current sample
  logic [4:0] pos;       // Position of current sample
  logic       vote;      // Majority of ticks 8-10
  logic       split;     // Samples 8-10 disagree
  logic       fall;      // High-to-low edge on samples
  logic       resync;    // Realign on this tick
  logic       boundary;  // Bit period ends on this tick
  logic [3:0] last_bit;  // Final data bit index
  logic [3:0] idle_thr;  // Idle threshold in bits
  logic       idle_fire; // Idle threshold first reached
  logic       wake_idle; // Idle line wakes standby
  logic       deliver;   // Character goes to software
  logic       msb;       // Most significant data bit
  logic       bus_req;   // New bus request
  logic       wr;        // Write taken this cycle
  logic       sel_ctrl;  // Control register addressed
  logic       sel_stat;  // Status register addressed
  logic       sel_baud;  // Baud register addressed
  logic [3:0] clr;       // Status bits cleared by write

  assign tk.divisor = baud_reg;
  assign tk.enable  = en_reg;

  ardr_tick_gen #(.DIV_W(DIV_W)) u_tick (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .tk    (tk)
  );

  // Two flops before anything looks at the pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end else begin
      rx_meta_reg <= rx_i;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  // Sample decode for the current tick
  always_comb begin
    samp     = rx_sync_reg;
    pos      = rt_reg + `ARDR_RT1;
    vote     = (s8_reg & s9_reg) | (s8_reg & samp) |
               (s9_reg & samp);
    split    = (s8_reg ^ s9_reg) | (s9_reg ^ samp);
    fall     = hist_reg[0] & ~samp;
    // Edge after a high bit, kept clear of the voting ticks
    resync   = prev_bit_reg & fall &
               ((state_reg == ARDR_DATA) ||
                (state_reg == ARDR_STOP)) &&
               ((pos <= `ARDR_SYNC_LATE) ||
                (pos >= `ARDR_SYNC_EARLY));
    // A late edge is the next bit's RT1, so close this bit
    boundary = (pos == `ARDR_RT16) ||
               (resync && (pos >= `ARDR_SYNC_EARLY));
    last_bit = char9_reg ? `ARDR_LAST_9 : `ARDR_LAST_8;
    idle_thr = char9_reg ? `ARDR_IDLE_9 : `ARDR_IDLE_8;
  end

  // Start hunt, verification and bit framing
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_reg) begin
      state_reg    <= ARDR_HUNT;
      rt_reg       <= '0;
      hist_reg     <= 3'h0;
      ones_reg     <= 2'h0;
      s8_reg       <= 1'b0;
      s9_reg       <= 1'b0;
      prev_bit_reg <= 1'b0;
      bit_idx_reg  <= 4'h0;
      shift_reg    <= 9'h000;
      cnoise_reg   <= 1'b0;
      done_reg     <= 1'b0;
      stop_ok_reg  <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (tk.tick) begin
        hist_reg <= {hist_reg[1:0], samp};
        if (pos == `ARDR_RT8) begin
          s8_reg <= samp;
        end
        if (pos == `ARDR_RT9) begin
          s9_reg <= samp;
        end
        case (state_reg)
          ARDR_HUNT: begin
            // Low preceded by three highs is RT1
            if (hist_reg == 3'h7 && !samp) begin
              state_reg  <= ARDR_START;
              rt_reg     <= `ARDR_RT1;
              ones_reg   <= 2'h0;
              cnoise_reg <= 1'b0;
            end else begin
              rt_reg <= '0;
            end
          end
          ARDR_START: begin
            rt_reg <= pos;
            if (pos == `ARDR_RT3 || pos == `ARDR_RT5) begin
              ones_reg <= ones_reg + {1'b0, samp};
            end
            if (pos == `ARDR_RT7) begin
              if (ones_reg + {1'b0, samp} >= 2'h2) begin
                state_reg <= ARDR_HUNT;
                rt_reg    <= '0;
              end else if (ones_reg[0] ^ samp) begin
                cnoise_reg <= 1'b1;
              end
            end
            // Late highs do not undo the accepted start
            if (pos >= `ARDR_RT8 && pos <= `ARDR_RT10 && samp) begin
              cnoise_reg <= 1'b1;
            end
            if (pos == `ARDR_RT16) begin
              state_reg    <= ARDR_DATA;
              rt_reg       <= '0;
              bit_idx_reg  <= 4'h0;
              prev_bit_reg <= 1'b0;
            end
          end
          ARDR_DATA: begin
            rt_reg <= resync ? `ARDR_RT1 : pos;
            if (resync) begin
              prev_bit_reg <= 1'b0;
            end
            if (pos == `ARDR_RT10) begin
              shift_reg[bit_idx_reg] <= vote;
              prev_bit_reg <= vote;
              if (split) begin
                cnoise_reg <= 1'b1;
              end
            end
            if (boundary) begin
              if (!resync) begin
                rt_reg <= '0;
              end
              if (bit_idx_reg == last_bit) begin
                state_reg <= ARDR_STOP;
              end else begin
                bit_idx_reg <= bit_idx_reg + 4'h1;
              end
            end
          end
          ARDR_STOP: begin
            rt_reg <= resync ? `ARDR_RT1 : pos;
            if (resync) begin
              prev_bit_reg <= 1'b0;
            end
            if (pos == `ARDR_RT10) begin
              stop_ok_reg <= vote;
              if (split) begin
                cnoise_reg <= 1'b1;
              end
              done_reg  <= 1'b1;
              state_reg <= ARDR_HUNT;
              rt_reg    <= '0;
            end
          end
          default: begin
            state_reg <= ARDR_HUNT;
          end
        endcase
      end
    end
  end

  // Consecutive high bit count for idle detection
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_reg) begin
      idle_tk_reg   <= 4'h0;
      idle_bits_reg <= 4'h0;
      idle_seen_reg <= 1'b0;
    end else begin
      if (idle_fire) begin
        idle_seen_reg <= 1'b1;
      end else if (idle_bits_reg != idle_thr) begin
        idle_seen_reg <= 1'b0;
      end
      // Fresh standby rearms so an idle line wakes at once
      if (wr && sel_ctrl && wb_sel_i[0] &&
          wb_dat_i[`ARDR_C_STANDBY]) begin
        idle_seen_reg <= 1'b0;
      end
      if (tk.tick) begin
        if (state_reg == ARDR_HUNT) begin
          if (!samp) begin
            idle_tk_reg   <= 4'h0;
            idle_bits_reg <= 4'h0;
          end else begin
            idle_tk_reg <= idle_tk_reg + 4'h1;
            if (idle_tk_reg == `ARDR_TICK_LAST &&
                idle_bits_reg != idle_thr) begin
              idle_bits_reg <= idle_bits_reg + 4'h1;
            end
          end
        end else if (pos == `ARDR_RT10) begin
          idle_tk_reg <= 4'h0;
          // After-stop origin ignores bits inside the character
          if (origin_reg || state_reg == ARDR_START ||
              !vote) begin
            idle_bits_reg <= 4'h0;
          end else if (idle_bits_reg != idle_thr) begin
            idle_bits_reg <= idle_bits_reg + 4'h1;
          end
        end
      end
    end
  end

  // Delivery and wake decisions
  always_comb begin
    idle_fire = (idle_bits_reg == idle_thr) && !idle_seen_reg;
    wake_idle = idle_fire && standby_reg && !wake_reg;
    msb       = char9_reg ? shift_reg[8] : shift_reg[7];
    deliver   = done_reg &&
                (!standby_reg || (wake_reg && msb));
  end

  // Bus decode
  always_comb begin
    bus_req  = wb_cyc_i && wb_stb_i && !ack_reg;
    wr       = bus_req && wb_we_i;
    sel_ctrl = 1'b0;
    sel_stat = 1'b0;
    sel_baud = 1'b0;
    if ({wb_adr_i[7:2], 2'h0} == `ARDR_OFF_CTRL) begin
      sel_ctrl = 1'b1;
    end else if ({wb_adr_i[7:2], 2'h0} == `ARDR_OFF_STATUS) begin
      sel_stat = 1'b1;
    end else if ({wb_adr_i[7:2], 2'h0} == `ARDR_OFF_BAUD) begin
      sel_baud = 1'b1;
    end
    clr = (wr && sel_stat && wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0;
  end

  // Control register; a software write beats a hardware wake
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {standby_reg, origin_reg, wake_reg, char9_reg, en_reg}
        <= `ARDR_CTRL_RST;
    end else if (wr && sel_ctrl && wb_sel_i[0]) begin
      en_reg      <= wb_dat_i[`ARDR_C_EN];
      char9_reg   <= wb_dat_i[`ARDR_C_CHAR9];
      wake_reg    <= wb_dat_i[`ARDR_C_WAKE];
      origin_reg  <= wb_dat_i[`ARDR_C_ORIGIN];
      standby_reg <= wb_dat_i[`ARDR_C_STANDBY];
    end else if (wake_idle || (done_reg && standby_reg &&
                 wake_reg && msb)) begin
      standby_reg <= 1'b0;
    end
  end

  // Baud divisor register, byte lanes honoured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      baud_reg <= DIV_W'(`ARDR_BAUD_RST);
    end else if (wr && sel_baud) begin
      for (int b = 0; b < DIV_W / 8; b++) begin
        if (wb_sel_i[b]) begin
          baud_reg[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
        end
      end
    end
  end

  // Status flags: write one clears, a new event wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      full_reg  <= 1'b0;
      noise_reg <= 1'b0;
      frame_reg <= 1'b0;
      idle_reg  <= 1'b0;
      data_reg  <= 9'h000;
    end else begin
      full_reg  <= (full_reg  & ~clr[`ARDR_S_FULL])  | deliver;
      noise_reg <= (noise_reg & ~clr[`ARDR_S_NOISE]) |
                   (deliver & cnoise_reg);
      // Same cycle as receive-full; a break lands here too
      frame_reg <= (frame_reg & ~clr[`ARDR_S_FRAME]) |
                   (deliver & ~stop_ok_reg);
      idle_reg  <= (idle_reg  & ~clr[`ARDR_S_IDLE])  |
                   (idle_fire & !wake_idle);
      if (deliver) begin
        // Eight-bit mode mirrors bit seven into bit eight
        data_reg <= char9_reg ? shift_reg :
                    {shift_reg[7], shift_reg[7:0]};
      end
    end
  end

  // Request output, silenced during standby
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_request_o <= 1'b0;
    end else begin
      rx_request_o <= en_reg && !standby_reg &&
                      (full_reg | noise_reg | frame_reg |
                       idle_reg);
    end
  end

  // Wishbone answer one clock after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg  <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_reg  <= bus_req;
      wb_dat_o <= 32'h0000_0000;
      if (bus_req && !wb_we_i) begin
        if (sel_ctrl) begin
          wb_dat_o[4:0] <= {standby_reg, origin_reg, wake_reg,
                            char9_reg, en_reg};
        end else if (sel_stat) begin
          wb_dat_o[3:0] <= {idle_reg, frame_reg, noise_reg,
                            full_reg};
        end else if ({wb_adr_i[7:2], 2'h0} == `ARDR_OFF_DATA) begin
          wb_dat_o[8:0] <= data_reg;
        end else if (sel_baud) begin
          wb_dat_o[DIV_W-1:0] <= baud_reg;
        end
      end
    end
  end

  assign wb_ack_o = ack_reg;
endmodule
`default_nettype wire

// ===== test/ardr_rx_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the register bus and the request pin of the receiver
module ardr_rx_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        rx_i,
  input wire logic        rx_request_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req;    // Fresh request on the bus
  logic ctl_wr; // Control write being taken
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign ctl_wr = req & wb_we_i & wb_sel_i[0] & (wb_adr_i[7:2] == 6'h00);
  chk_ack_next: assert property (req |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_cause: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  chk_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  chk_reset_quiet: assert property ($fell(rst_i) |-> !rx_request_o)
    else $error("request high after reset");
  chk_standby_mute: assert property (
    ctl_wr && wb_dat_i[4] |-> ##2 !rx_request_o)
    else $error("request while in standby");
  chk_disable_mute: assert property (
    ctl_wr && !wb_dat_i[0] |-> ##2 !rx_request_o)
    else $error("request while disabled");
  chk_status_width: assert property (wb_ack_o && $past(wb_adr_i[7:2]) == 6'h01
    |-> wb_dat_o[31:4] == 28'h0) else $error("status upper bits set");
  chk_unmapped_zero: assert property (wb_ack_o && $past(wb_adr_i[7:2]) > 6'h03
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  // Main scenarios reached
  cover property (ctl_wr && wb_dat_i[4]);
  cover property ($rose(rx_request_o));
  cover property ($fell(rx_i));
endmodule
bind ardr_receiver ardr_rx_monitor u_ardr_rx_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .rx_i(rx_i), .rx_request_o(rx_request_o)
);
`default_nettype wire

// ===== test/ardr_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
// Remote transmitter; line rests at mark between frames
module ardr_tx_model (
  input  wire logic clk_i,
  output var  logic line_o
);
  initial line_o = 1'b1; // Mark level, like the pulled-up wire
  // Start, nb data bits LSB first, stop level stp; bt clocks a bit.
  // Four clocks of bit gb from clock go are inverted to make noise.
  task automatic send(input logic [8:0] d, input int nb, input logic stp,
                      input int bt, input int gb, input int go);
    logic b;
    for (int i = 0; i < nb + 2; i++) begin
      b = (i == 0) ? 1'b0 : (i == nb + 1) ? stp : d[i-1];
      for (int c = 0; c < bt; c++) begin
        @(posedge clk_i);
        line_o <= (i == gb && c >= go && c < go + 4) ? ~b : b;
      end
    end
    @(posedge clk_i);
    line_o <= 1'b1; // Back to mark even after a break
  endtask
  // Short low glitch, too short to pass as a start bit
  task automatic pulse(input int n);
    @(posedge clk_i);
    line_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    line_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== test/ardr_receiver_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ardr_receiver_tb;
  logic        clk_i, rst_i, cyc, stb, we, ack, rx, req;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, v;
  int          bad_count, checked;
  int          cyc_n = 0; // Hang guard

  ardr_receiver #(.DIV_W(16)) u_ardr_receiver (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .rx_i(rx), .rx_request_o(req));
  ardr_tx_model u_ardr_tx_model (.clk_i(clk_i), .line_o(rx));

  // 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task complete_run;
    if (bad_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Whole run needs about 12k cycles
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 60000) begin
      bad_count++;
      complete_run;
    end
  end

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  // Classic cycle; held until ack is sampled high
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hF;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    v = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task rdc(input string n, input logic [7:0] a, input logic [31:0] m,
           input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, v & m, e);
  endtask

  task clr; bus(1'b1, 8'h04, 32'h0000000F); endtask

  // One character, then its flags and data
  task rxc(input logic [8:0] d, input int nb, input logic stp, input int bt,
           input int gb, input int go, input logic [31:0] st, dt);
    clr;
    u_ardr_tx_model.send(d, nb, stp, bt, gb, go);
    repeat (8) @(posedge clk_i);
    rdc("flags", 8'h04, 32'h7, st);
    rdc("data", 8'h08, 32'h1FF, dt);
  endtask

  task t_regs;
    rdc("ctrl rst", 8'h00, 32'hFFFFFFFF, 32'h0);
    rdc("baud rst", 8'h0C, 32'hFFFFFFFF, 32'h41);
    rdc("unmapped", 8'h10, 32'hFFFFFFFF, 32'h0);
    bus(1'b1, 8'h08, 32'h55); // Data is read-only
    rdc("data ro", 8'h08, 32'hFFFFFFFF, 32'h0);
    bus(1'b1, 8'h0C, 32'h4);
    bus(1'b1, 8'h00, 32'h1);
    // Hunt needs three high ticks before the first start edge
    repeat (64) @(posedge clk_i);
  endtask

  // Noise on start at the fifth and ninth tick, on data and on stop
  task t_noise;
    rxc(9'h0FF, 8, 1'b1, 64, 0, 16, 32'h3, 32'h1FF);
    rxc(9'h0FF, 8, 1'b1, 64, 0, 32, 32'h3, 32'h1FF);
    rxc(9'h0FF, 8, 1'b1, 64, 4, 32, 32'h3, 32'h1FF);
    rxc(9'h0FF, 8, 1'b1, 64, 9, 32, 32'h3, 32'h1FF);
  endtask

  task t_reject;
    clr;
    u_ardr_tx_model.pulse(8);
    repeat (128) @(posedge clk_i);
    rdc("reject", 8'h04, 32'h7, 32'h0);
    rxc(9'h03C, 8, 1'b1, 64, -1, 0, 32'h1, 32'h03C);
  endtask

  // Idle count origin after start, then after stop
  task t_idle;
    for (int o = 0; o < 2; o++) begin
      bus(1'b1, 8'h00, {28'h0, o[0], 3'b001});
      clr;
      u_ardr_tx_model.send(9'h0FF, 8, 1'b1, 64, -1, 0);
      repeat (192) @(posedge clk_i);
      rdc("idle early", 8'h04, 32'h8, o ? 32'h0 : 32'h8);
      repeat (704) @(posedge clk_i);
      rdc("idle late", 8'h04, 32'h8, 32'h8);
    end
    bus(1'b1, 8'h00, 32'h1);
    clr;
    bus(1'b1, 8'h00, 32'h11);
    repeat (768) @(posedge clk_i);
    rdc("idle wake", 8'h00, 32'h1F, 32'h01);
    rdc("wake flags", 8'h04, 32'hF, 32'h0);
  endtask

  // Address mark wake in standby
  task t_addr;
    bus(1'b1, 8'h00, 32'h15);
    clr;
    u_ardr_tx_model.send(9'h012, 8, 1'b1, 64, -1, 0);
    repeat (8) @(posedge clk_i);
    rdc("dropped", 8'h04, 32'h7, 32'h0);
    rxc(9'h081, 8, 1'b1, 64, -1, 0, 32'h1, 32'h181);
    rdc("awake", 8'h00, 32'h1F, 32'h05);
    chk("request", {31'h0, req}, 32'h1);
    bus(1'b1, 8'h00, 32'h15);
    repeat (2) @(posedge clk_i);
    chk("muted", {31'h0, req}, 32'h0);
    clr;
    u_ardr_tx_model.send(9'h022, 8, 1'b1, 64, -1, 0);
    repeat (8) @(posedge clk_i);
    rdc("ignored", 8'h04, 32'h7, 32'h0);
    bus(1'b1, 8'h00, 32'h1);
  endtask

  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0;
    rst_i = 1'b1;
    bad_count = 0;
    checked = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    rxc(9'h0A5, 8, 1'b1, 64, -1, 0, 32'h1, 32'h1A5);
    chk("request", {31'h0, req}, 32'h1);
    // Disabling drops the request even with a flag still set
    bus(1'b1, 8'h00, 32'h0);
    repeat (2) @(posedge clk_i);
    chk("disabled", {31'h0, req}, 32'h0);
    bus(1'b1, 8'h00, 32'h1);
    // Hunt restarts from reset history, so let it see idle first
    repeat (64) @(posedge clk_i);
    rxc(9'h000, 8, 1'b0, 64, -1, 0, 32'h5, 32'h0);
    t_noise;
    t_reject;
    rxc(9'h055, 8, 1'b1, 69, -1, 0, 32'h1, 32'h055);
    bus(1'b1, 8'h00, 32'h3);
    rxc(9'h15A, 9, 1'b1, 64, -1, 0, 32'h1, 32'h15A);
    t_idle;
    t_addr;
    complete_run;
  end
endmodule
`default_nettype wire
